// ### include/backup_pmic_regs.svh
// Register offsets, field positions and reset values of the backup power manager
`ifndef BACKUP_PMIC_REGS_SVH
`define BACKUP_PMIC_REGS_SVH

`define OFS_CHIP_ID 8'h00
`define OFS_SYS_CTRL1 8'h01
`define OFS_EVT_STATUS1 8'h02
`define OFS_EVT_MASK1 8'h04
`define OFS_STORE_THR 8'h06
`define OFS_TEMP_LEVEL 8'h07
`define OFS_TIMER_LO 8'h16
`define OFS_TIMER_HI 8'h17
`define OFS_SYS_CTRL2 8'h20
`define OFS_SYS_CTRL3 8'h21
`define OFS_SYS_CTRL4 8'h22

`define ID_FAB_LSB 6
`define ID_MAJOR_LSB 4
`define ID_MINOR_LSB 2
`define ID_VENDOR_LSB 0

`define BIT_CAP_START 3
`define BIT_ADC_START 2
`define BIT_BOOST_EN 0

`define BIT_CAP_DONE 7
`define BIT_ADC_DONE 6
`define BIT_OVERCURRENT 4
`define BIT_OVERVOLT 3
`define BIT_STORE_LOW 2
`define BIT_TEMP_WARN 0

`define STATUS1_VALID 8'hDD
`define RST_STATUS1 8'h04
`define RST_MASK1 8'h04
`define RST_STORE_THR 8'h3F
`define STORE_THR_VALID 8'h3F
`define RST_TEMP_LEVEL 8'h1F
`define TEMP_LEVEL_VALID 8'h1F
`define RST_SYS_CTRL2 8'h88
`define RST_SYS_CTRL3 8'h01
`define RST_SYS_CTRL4 8'h00

`define DEF_DEV_ADDR 7'h60

`endif

// ### include/backup_pmic_pkg.sv
// Types shared by the backup power manager register logic
package backup_pmic_pkg;

    typedef logic [7:0] byte_t;

    typedef enum {
        S_IDLE,
        S_ADDR,
        S_ACK_ADDR,
        S_REG,
        S_ACK_REG,
        S_WRITE,
        S_ACK_WRITE,
        S_READ,
        S_RD_ACK
    } serial_state_t;

endpackage

// ### include/reg_link_if.sv
// Register access link between the serial port engine and the register bank
`timescale 1ns/1ps
interface reg_link_if;
    import backup_pmic_pkg::*;
    byte_t addr;
    byte_t wdata;
    byte_t rdata;
    logic wr_stb;
    modport serial (output addr, output wdata, output wr_stb, input rdata);
    modport bank (input addr, input wdata, input wr_stb, output rdata);
endinterface

// ### rtl/serial_reg_port.sv
// Two-wire serial slave that turns bus transfers into register reads and writes
`timescale 1ns/1ps
`include "backup_pmic_regs.svh"
module serial_reg_port
    import backup_pmic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `DEF_DEV_ADDR
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    reg_link_if.serial link
);
    // Index 0 is the first synchroniser stage, 1 the second, 2 a delayed copy
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    serial_state_t state_q;
    logic [3:0] cnt_q;
    byte_t shift_q;
    byte_t ptr_q;
    byte_t wdata_q;
    logic rnw_q;
    logic oe_q;
    logic wr_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda_i};
        end
    end

    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_seen = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_seen = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            wdata_q <= 8'h00;
            rnw_q <= 1'h0;
            oe_q <= 1'h0;
            wr_q <= 1'h0;
        end
        else
        begin
            wr_q <= 1'h0;
            if (start_seen)
            begin
                state_q <= S_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'h0;
            end
            else if (stop_seen)
            begin
                state_q <= S_IDLE;
                oe_q <= 1'h0;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        oe_q <= 1'h0;
                    end
                    S_ADDR, S_REG, S_WRITE:
                    begin
                        if (scl_rise && cnt_q != 4'h8)
                        begin
                            shift_q <= {shift_q[6:0], sda_s[1]};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (scl_fall && cnt_q == 4'h8)
                        begin
                            cnt_q <= 4'h0;
                            if (state_q == S_ADDR)
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    oe_q <= 1'h1;
                                    rnw_q <= shift_q[0];
                                    state_q <= S_ACK_ADDR;
                                end
                                else
                                begin
                                    state_q <= S_IDLE;
                                end
                            end
                            else if (state_q == S_REG)
                            begin
                                ptr_q <= shift_q;
                                oe_q <= 1'h1;
                                state_q <= S_ACK_REG;
                            end
                            else
                            begin
                                // Register updates on the falling edge after the last bit
                                wr_q <= 1'h1;
                                wdata_q <= shift_q;
                                oe_q <= 1'h1;
                                state_q <= S_ACK_WRITE;
                            end
                        end
                    end
                    S_ACK_ADDR, S_ACK_REG, S_ACK_WRITE:
                    begin
                        if (scl_fall)
                        begin
                            oe_q <= 1'h0;
                            if (state_q == S_ACK_ADDR && rnw_q)
                            begin
                                shift_q <= link.rdata;
                                oe_q <= ~link.rdata[7];
                                ptr_q <= ptr_q + 8'h01;
                                cnt_q <= 4'h0;
                                state_q <= S_READ;
                            end
                            else if (state_q == S_ACK_ADDR)
                            begin
                                state_q <= S_REG;
                            end
                            else
                            begin
                                if (state_q == S_ACK_WRITE)
                                begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                                state_q <= S_WRITE;
                            end
                        end
                    end
                    S_READ:
                    begin
                        if (scl_fall)
                        begin
                            if (cnt_q == 4'h7)
                            begin
                                oe_q <= 1'h0;
                                cnt_q <= 4'h0;
                                state_q <= S_RD_ACK;
                            end
                            else
                            begin
                                shift_q <= {shift_q[6:0], 1'h0};
                                oe_q <= ~shift_q[6];
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    S_RD_ACK:
                    begin
                        if (scl_rise && sda_s[1])
                        begin
                            state_q <= S_IDLE;
                        end
                        else if (scl_fall)
                        begin
                            shift_q <= link.rdata;
                            oe_q <= ~link.rdata[7];
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= S_READ;
                        end
                    end
                    default:
                    begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_o = 1'h0;
    assign sda_oe = oe_q;
    assign link.addr = ptr_q;
    assign link.wdata = wdata_q;
    assign link.wr_stb = wr_q;
endmodule

// ### rtl/backup_pmic_control_status_regs.sv
// Control and event-status registers of the backup power manager
// Operation
// - Writing 1 to the capacitor-test start bit starts a test; self-clears when done.
// - Writing 1 to the converter start bit starts a conversion; self-clears when done.
// - Boost charge enable resets to 1; writes ignored in buck mode.
// - Clearing boost charge enable never blocks the later buck release.
// - Test completion stores discharge time and sets the test-done flag.
// - Conversion completion sets the conversion-done flag, raising interrupt unless masked.
// - Status flags clear only by writing 1, which also withdraws the interrupt.
// - Input current at limit sets the overcurrent flag.
// - Overvoltage sense above threshold sets the overvoltage flag.
// - Storage-not-good resets to 1, sets on low storage and drives the interrupt, not the pin.
// - Storage power-good pin returns high when storage recovers, whatever the flag.
// - Temperature warning sets only when result strictly exceeds the warning level.
// - Identification register is read only with fab, major, minor, vendor fields.
// - A set mask bit lets the flag latch but blocks the interrupt.
`timescale 1ns/1ps
`include "backup_pmic_regs.svh"
module backup_pmic_control_status_regs
    import backup_pmic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `DEF_DEV_ADDR,
    // Identification values are arbitrary
    parameter logic [1:0] FAB_CODE = 2'h1,
    parameter logic [1:0] MAJOR_REV = 2'h1,
    parameter logic [1:0] MINOR_REV = 2'h2,
    parameter logic [1:0] VENDOR_CODE = 2'h3
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic cap_test_done_in,
    input wire logic [15:0] cap_test_time,
    input wire logic adc_done_in,
    input wire logic temp_valid_in,
    input wire logic [7:0] temp_result,
    input wire logic current_limit_in,
    input wire logic overvoltage_sense_input,
    input wire logic storage_voltage_low,
    input wire logic buck_mode_in,
    output logic cap_test_start,
    output logic adc_start,
    output logic boost_charge_enable,
    output logic [7:0] ctrl_two,
    output logic [7:0] ctrl_three,
    output logic [7:0] ctrl_four,
    output logic [5:0] storage_threshold,
    output logic int_b,
    output logic storage_power_good_pin
);
    localparam int NSYNC = 31;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    reg_link_if link ();

    serial_reg_port #(
        .DEV_ADDR(DEV_ADDR)
    ) serial_reg_port_i (
        .clock(clock),
        .rst_b(rst_b),
        .scl(scl),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .link(link)
    );

    // Analog inputs: the first stage feeds only the second
    logic [NSYNC-1:0] in_vec;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [2:0] s3_q;
    logic cap_evt;
    logic adc_evt;
    logic temp_evt;
    logic ilim_s;
    logic ovp_s;
    logic store_low_s;
    logic buck_s;
    logic [15:0] cap_time_s;
    byte_t temp_s;

    assign in_vec = {temp_result, cap_test_time, buck_mode_in, storage_voltage_low,
        overvoltage_sense_input, current_limit_in, temp_valid_in, adc_done_in,
        cap_test_done_in};

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= 3'h0;
        end
        else
        begin
            s1_q <= in_vec;
            s2_q <= s1_q;
            s3_q <= s2_q[2:0];
        end
    end

    // Completion data must be stable before its done edge reaches the first stage
    assign cap_evt = s2_q[0] & ~s3_q[0];
    assign adc_evt = s2_q[1] & ~s3_q[1];
    assign temp_evt = s2_q[2] & ~s3_q[2];
    assign ilim_s = s2_q[3];
    assign ovp_s = s2_q[4];
    assign store_low_s = s2_q[5];
    assign buck_s = s2_q[6];
    assign cap_time_s = s2_q[22:7];
    assign temp_s = s2_q[30:23];

    // Register bank
    byte_t id_word;
    byte_t status_q;
    byte_t status_d;
    byte_t set_vec;
    byte_t clr_vec;
    byte_t mask_q;
    byte_t store_thr_q;
    byte_t temp_level_q;
    byte_t ctrl2_q;
    byte_t ctrl3_q;
    byte_t ctrl4_q;
    logic [15:0] timer_q;
    logic cap_start_q;
    logic adc_start_q;
    logic boost_q;
    logic int_b_q;
    logic pgs_q;
    logic wr_sys1;
    logic wr_status;

    assign wr_sys1 = link.wr_stb && link.addr == `OFS_SYS_CTRL1;
    assign wr_status = link.wr_stb && link.addr == `OFS_EVT_STATUS1;

    always_comb
    begin
        id_word = 8'h00;
        id_word[`ID_FAB_LSB +: 2] = FAB_CODE;
        id_word[`ID_MAJOR_LSB +: 2] = MAJOR_REV;
        id_word[`ID_MINOR_LSB +: 2] = MINOR_REV;
        id_word[`ID_VENDOR_LSB +: 2] = VENDOR_CODE;
    end

    // Start bits: a completion clears the bit; a write in that same cycle restarts it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_start_q <= 1'h0;
            adc_start_q <= 1'h0;
        end
        else
        begin
            if (wr_sys1 && link.wdata[`BIT_CAP_START])
                cap_start_q <= 1'h1;
            else if (cap_evt)
                cap_start_q <= 1'h0;
            if (wr_sys1 && link.wdata[`BIT_ADC_START])
                adc_start_q <= 1'h1;
            else if (adc_evt)
                adc_start_q <= 1'h0;
        end
    end

    a_cap_self_clear: assert property (cap_evt && !wr_sys1 |=> !cap_start_q)
        else $error("capacitor test start bit did not self-clear");
    a_adc_self_clear: assert property (adc_evt && !wr_sys1 |=> !adc_start_q)
        else $error("converter start bit did not self-clear");

    // Buck release lives in ctrl2 and is never gated by this bit
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            boost_q <= 1'h1;
        else if (wr_sys1 && !buck_s)
            boost_q <= link.wdata[`BIT_BOOST_EN];
    end

    a_boost_buck_lock: assert property (wr_sys1 && buck_s |=> $stable(boost_q))
        else $error("boost enable changed by a write in buck mode");

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            timer_q <= 16'h0000;
        else if (cap_evt)
            timer_q <= cap_time_s;
    end

    // Event flags: a set in the cycle of a clearing write wins
    always_comb
    begin
        set_vec = 8'h00;
        set_vec[`BIT_CAP_DONE] = cap_evt;
        set_vec[`BIT_ADC_DONE] = adc_evt;
        set_vec[`BIT_OVERCURRENT] = ilim_s;
        set_vec[`BIT_OVERVOLT] = ovp_s;
        set_vec[`BIT_STORE_LOW] = store_low_s;
        set_vec[`BIT_TEMP_WARN] = temp_evt && temp_s > {3'h0, temp_level_q[4:0]};
        clr_vec = wr_status ? (link.wdata & `STATUS1_VALID) : 8'h00;
        status_d = (status_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            status_q <= `RST_STATUS1;
        else
            status_q <= status_d;
    end

    a_cap_done_flag: assert property (cap_evt |=> status_q[7]
        && timer_q == $past(cap_time_s))
        else $error("test completion did not set flag and store time");
    a_adc_done_flag: assert property (adc_evt |=> status_q[6]
        ##1 status_q[6] || $past(wr_status))
        else $error("conversion completion did not set its flag");
    a_w1c_only: assert property ($fell(status_q[7]) |->
        $past(wr_status && link.wdata[7]))
        else $error("test-done flag cleared without a write of 1");
    a_ilim_flag: assert property (ilim_s |=> status_q[4])
        else $error("overcurrent flag not set during current limit");
    a_ovp_flag: assert property (ovp_s && wr_status |=> status_q[3])
        else $error("overvoltage flag lost during active condition");
    a_temp_equal: assert property (temp_evt && temp_s == {3'h0, temp_level_q[4:0]}
        && !status_q[0] |=> !status_q[0])
        else $error("temperature warning set on equal result");

    // Settings registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_q <= `RST_MASK1;
            store_thr_q <= `RST_STORE_THR;
            temp_level_q <= `RST_TEMP_LEVEL;
        end
        else if (link.wr_stb)
        begin
            case (link.addr)
                `OFS_EVT_MASK1: mask_q <= link.wdata & `STATUS1_VALID;
                `OFS_STORE_THR: store_thr_q <= link.wdata & `STORE_THR_VALID;
                `OFS_TEMP_LEVEL: temp_level_q <= link.wdata & `TEMP_LEVEL_VALID;
                default: mask_q <= mask_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl2_q <= `RST_SYS_CTRL2;
            ctrl3_q <= `RST_SYS_CTRL3;
            ctrl4_q <= `RST_SYS_CTRL4;
        end
        else if (link.wr_stb)
        begin
            case (link.addr)
                `OFS_SYS_CTRL2: ctrl2_q <= link.wdata;
                `OFS_SYS_CTRL3: ctrl3_q <= link.wdata;
                `OFS_SYS_CTRL4: ctrl4_q <= link.wdata;
                default: ctrl2_q <= ctrl2_q;
            endcase
        end
    end

    // Interrupt and storage pin: pin follows the voltage, not the sticky flag
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_b_q <= 1'h1;
            pgs_q <= 1'h0;
        end
        else
        begin
            int_b_q <= ~|(status_q & ~mask_q);
            pgs_q <= ~store_low_s;
        end
    end

    a_int_follows: assert property (##1 int_b_q == !$past(|(status_q & ~mask_q)))
        else $error("interrupt output does not follow unmasked flags");
    a_pgs_recover: assert property (!store_low_s |=> storage_power_good_pin)
        else $error("storage power-good pin did not return high");

    // Read data; reserved bits and unmapped offsets read zero
    always_comb
    begin
        case (link.addr)
            `OFS_CHIP_ID: link.rdata = id_word;
            `OFS_SYS_CTRL1: link.rdata = {4'h0, cap_start_q, adc_start_q, 1'h0, boost_q};
            `OFS_EVT_STATUS1: link.rdata = status_q;
            `OFS_EVT_MASK1: link.rdata = mask_q;
            `OFS_STORE_THR: link.rdata = store_thr_q;
            `OFS_TEMP_LEVEL: link.rdata = temp_level_q;
            `OFS_TIMER_LO: link.rdata = timer_q[7:0];
            `OFS_TIMER_HI: link.rdata = timer_q[15:8];
            `OFS_SYS_CTRL2: link.rdata = ctrl2_q;
            `OFS_SYS_CTRL3: link.rdata = ctrl3_q;
            `OFS_SYS_CTRL4: link.rdata = ctrl4_q;
            default: link.rdata = 8'h00;
        endcase
    end

    // Checked against the field order, so a misplaced field shows up
    a_id_read_only: assert property (link.addr == `OFS_CHIP_ID |->
        link.rdata == {FAB_CODE, MAJOR_REV, MINOR_REV, VENDOR_CODE})
        else $error("identification read value wrong");

    assign cap_test_start = cap_start_q;
    assign adc_start = adc_start_q;
    assign boost_charge_enable = boost_q;
    assign ctrl_two = ctrl2_q;
    assign ctrl_three = ctrl3_q;
    assign ctrl_four = ctrl4_q;
    assign storage_threshold = store_thr_q[5:0];
    assign int_b = int_b_q;
    assign storage_power_good_pin = pgs_q;
endmodule

// ### test/serial_host_model.sv
// Two-wire bus host that reads and writes the register bank
`timescale 1ns/1ps
`include "backup_pmic_regs.svh"
module serial_host_model
    import backup_pmic_pkg::*;
(
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    logic ack_ok;
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
        ack_ok = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // SDA moves two clocks into SCL low so the synchroniser never sees a false START
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        pull <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(5);
        @(negedge clock);
        r = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        pull <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(6);
        pull <= 1'b1;
        tick(6);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(6);
        pull <= 1'b0;
        tick(6);
    endtask
    // Host never acknowledges; reads are single bytes ended by a NACK
    task automatic xfer(input byte_t d, input logic chk, output byte_t q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, a);
        if (chk && a)
            ack_ok = 1'b0;
    endtask
    task automatic write_reg(input byte_t ofs, input byte_t d);
        byte_t q;
        start();
        xfer({`DEF_DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ofs, 1'b1, q);
        xfer(d, 1'b1, q);
        stop();
    endtask
    task automatic read_reg(input byte_t ofs, output byte_t d);
        byte_t q;
        start();
        xfer({`DEF_DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ofs, 1'b1, q);
        start();
        xfer({`DEF_DEV_ADDR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b0, d);
        stop();
    endtask
endmodule

// ### test/backup_pmic_control_status_regs_test.sv
// Random and corner-case bench for the control and event-status registers
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module backup_pmic_control_status_regs_test
    import backup_pmic_pkg::*;
;
    logic clock, rst_b, scl, pull, sda, sda_o, sda_oe;
    logic cap_test_done_in, adc_done_in, temp_valid_in, current_limit_in;
    logic overvoltage_sense_input, storage_voltage_low, buck_mode_in;
    logic cap_test_start, adc_start, boost_charge_enable, int_b, storage_power_good_pin;
    logic [15:0] cap_test_time;
    logic [5:0] storage_threshold;
    byte_t temp_result, ctrl_two, ctrl_three, ctrl_four, rd, v, lvl;
    int seed = 55;
    int miscompares = 0;
    int comparisons = 0;
    // Open-drain line with pull-up
    assign sda = !(pull || sda_oe);
    backup_pmic_control_status_regs backup_pmic_control_status_regs_i (
        .clock, .rst_b, .scl, .sda_i(sda), .sda_o, .sda_oe, .cap_test_done_in, .cap_test_time,
        .adc_done_in, .temp_valid_in, .temp_result, .current_limit_in, .overvoltage_sense_input,
        .storage_voltage_low, .buck_mode_in, .cap_test_start, .adc_start, .boost_charge_enable,
        .ctrl_two, .ctrl_three, .ctrl_four, .storage_threshold, .int_b, .storage_power_good_pin);
    serial_host_model serial_host_model_i (.clock, .sda, .scl, .pull);
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic byte_t exp_id();
        return {2'h1, 2'h1, 2'h2, 2'h3};
    endfunction
    function automatic logic warn(input byte_t r, input byte_t l);
        return r > l;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input byte_t ofs, input byte_t d);
        serial_host_model_i.write_reg(ofs, d);
    endtask
    task automatic expect_reg(input byte_t ofs, input byte_t e);
        serial_host_model_i.read_reg(ofs, rd);
        `CHK(rd, e)
    endtask
    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        miscompares++;
        $display("[FAIL] %0t run timed out", $time);
        summarize();
    end
    initial
    begin
        rst_b = 1'b0;
        {cap_test_done_in, adc_done_in, temp_valid_in, current_limit_in} = '0;
        {overvoltage_sense_input, storage_voltage_low, buck_mode_in} = '0;
        cap_test_time = '0;
        temp_result = '0;
        tick(4);
        rst_b <= 1'b1;
        tick(4);
        `CHK(boost_charge_enable, 1'b1)
        `CHK(int_b, 1'b1)
        `CHK(sda_o, 1'b0)
        `CHK({ctrl_two, ctrl_three, ctrl_four, storage_threshold}, {24'h8801_00, 6'h3F})
        expect_reg(8'h00, exp_id());
        wr(8'h00, 8'h00);
        expect_reg(8'h00, exp_id());
        expect_reg(8'h01, 8'h01);
        expect_reg(8'h02, 8'h04);
        v = byte_t'($random(seed));
        wr(8'h22, v);
        `CHK(ctrl_four, v)
        wr(8'h06, v & 8'h3F);
        wr(8'h21, v);
        `CHK({ctrl_three, storage_threshold}, {v, v[5:0]})
        done_test("reset");
        // Reserved bits are always written back as zero, their read value
        wr(8'h01, 8'h00);
        `CHK(boost_charge_enable, 1'b0)
        wr(8'h20, 8'h89);
        `CHK(ctrl_two, 8'h89)
        buck_mode_in <= 1'b1;
        wr(8'h01, 8'h01);
        `CHK(boost_charge_enable, 1'b0)
        buck_mode_in <= 1'b0;
        wr(8'h01, 8'h01);
        `CHK(boost_charge_enable, 1'b1)
        done_test("boost");
        wr(8'h1B, 8'h02);
        expect_reg(8'h1B, 8'h00);
        cap_test_time <= 16'($random(seed));
        wr(8'h01, 8'h09);
        `CHK(cap_test_start, 1'b1)
        cap_test_done_in <= 1'b1;
        tick(6);
        `CHK(cap_test_start, 1'b0)
        `CHK(int_b, 1'b0)
        expect_reg(8'h02, 8'h84);
        expect_reg(8'h16, cap_test_time[7:0]);
        expect_reg(8'h17, cap_test_time[15:8]);
        wr(8'h02, 8'h80);
        `CHK(int_b, 1'b1)
        cap_test_done_in <= 1'b0;
        wr(8'h1B, 8'h00);
        done_test("cap");
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h04, m ? 8'h44 : 8'h04);
            wr(8'h01, 8'h05);
            `CHK(adc_start, 1'b1)
            adc_done_in <= 1'b1;
            tick(6);
            `CHK(adc_start, 1'b0)
            `CHK(int_b, m[0])
            wr(8'h02, 8'h00);
            expect_reg(8'h02, 8'h44);
            wr(8'h02, 8'h40);
            expect_reg(8'h02, 8'h04);
            adc_done_in <= 1'b0;
        end
        done_test("adc");
        wr(8'h04, 8'h04);
        for (int k = 0; k < 2; k++)
        begin
            {current_limit_in, overvoltage_sense_input} <= k ? 2'b01 : 2'b10;
            tick(6);
            `CHK(int_b, 1'b0)
            v = k ? 8'h08 : 8'h10;
            wr(8'h02, v);
            expect_reg(8'h02, v | 8'h04);
            {current_limit_in, overvoltage_sense_input} <= 2'b00;
            wr(8'h02, v);
            expect_reg(8'h02, 8'h04);
            `CHK(int_b, 1'b1)
        end
        done_test("level");
        storage_voltage_low <= 1'b1;
        tick(6);
        `CHK(storage_power_good_pin, 1'b0)
        wr(8'h04, 8'h00);
        `CHK(int_b, 1'b0)
        storage_voltage_low <= 1'b0;
        tick(6);
        `CHK(storage_power_good_pin, 1'b1)
        wr(8'h02, 8'h04);
        `CHK(int_b, 1'b1)
        done_test("storage");
        lvl = byte_t'($random(seed)) & 8'h1E;
        wr(8'h07, lvl);
        for (int t = 0; t < 3; t++)
        begin
            v = (t == 2) ? 8'h00 : byte_t'(lvl + t);
            temp_result <= v;
            tick(4);
            temp_valid_in <= 1'b1;
            tick(6);
            temp_valid_in <= 1'b0;
            `CHK(int_b, ~warn(v, lvl) & (t != 2))
        end
        wr(8'h02, 8'h01);
        expect_reg(8'h02, 8'h00);
        `CHK(serial_host_model_i.ack_ok, 1'b1)
        done_test("temp");
        summarize();
    end
endmodule
